// ---- design/bfbt_breaker_failure_stage.sv ----
// Function
// - watch chosen primary trip control signal and time its assertion
// - if asserted past operate time, trip and drive backup relay
// - backup relay holds until the primary trip signal drops
// - act on combined relay control, any routed function starts timer
// - selection 1 watches relay one, 2 relay two; shared with monitoring
// - report status as blocked, started or tripped
// - count starts and trips separately; each clearable by write
// - shared force flag, cleared automatically after five minutes
// - started/tripped status writable only while force flag set
// - settings accept changes only after valid password
// - keep eight latest faults with date, ms time and delay
// - recorded delay is percent of operate time; 100 means operate time reached
`timescale 1ns/1ps
`include "bfbt_cfg.svh"
module bfbt_breaker_failure_stage
#(
   parameter logic [31:0] FORCE_CYCLES = `BFBT_FORCE_CYCLES, // force timeout
   parameter logic [31:0] MS_CYCLES    = `BFBT_MS_CYCLES     // 1 ms tick
)
(
   input  wire logic        clk_sys_i,          // 10 MHz clock
   input  wire logic        resetn_i,           // async reset, low
   input  wire logic        trip_relay_one_i,   // relay one control, async
   input  wire logic        trip_relay_two_i,   // relay two control, async
   input  wire logic        wb_cyc_i,           // wishbone cycle
   input  wire logic        wb_stb_i,           // wishbone strobe
   input  wire logic        wb_we_i,            // wishbone write
   input  wire logic [7:0]  wb_adr_i,           // byte address
   input  wire logic [3:0]  wb_sel_i,           // byte enables
   input  wire logic [31:0] wb_dat_i,           // write data
   output logic [31:0]      wb_dat_o,           // read data
   output logic             wb_ack_o,           // acknowledge
   output logic             backup_trip_o,      // backup relay drive
   output logic             stage_start_o,      // start indication
   output logic [1:0]       relay_sel_o,        // shared relay selection
   output logic             force_o             // shared force flag
);
   import bfbt_pkg::*;

   logic              relay_one_s;
   logic              relay_two_s;
   logic              watched;
   logic              ack_ff;
   logic [31:0]       dat_ff;
   logic [1:0]        sel_ff;
   logic              blk_ff;
   logic [31:0]       optime_ff;
   logic              unlock_ff;
   logic              force_ff;
   logic [31:0]       force_cnt_ff;
   logic [31:0]       scnt_ff;
   logic [31:0]       tcnt_ff;
   bfbt_state_e       state_ff;
   logic [31:0]       elapsed_ff;
   logic [1:0]        fstat_ff;
   logic [31:0]       date_ff;
   logic [31:0]       tod_ff;
   logic [31:0]       ms_cnt_ff;
   logic [2:0]        wptr_ff;
   logic [3:0]        rcnt_ff;
   logic [2:0]        ridx_ff;
   logic              wb_req;
   logic              wr_stb;
   logic              expire;
   logic [1:0]        status;
   bfbt_rec_s         new_rec;

   bfbt_rec_if rec ();

   function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // percent of operate time, clipped at 100
   function automatic logic [15:0] pct(input logic [31:0] el,
                                       input logic [31:0] op);
      logic [39:0] num;
      logic [39:0] q;
      num = {8'h00, el} * 40'd100;
      q   = (op == 32'h0000_0000) ? 40'd100 : num / {8'h00, op};
      return (q > 40'd100) ? 16'd100 : q[15:0];
   endfunction

   bfbt_sync u_sync_one
   (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .d_i       (trip_relay_one_i),
      .q_o       (relay_one_s)
   );

   bfbt_sync u_sync_two
   (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .d_i       (trip_relay_two_i),
      .q_o       (relay_two_s)
   );

   bfbt_rec_mem u_rec
   (
      .clk_sys_i (clk_sys_i),
      .rec       (rec.mem)
   );

   // combined control of chosen relay, whatever function drives it
   assign watched = (sel_ff == 2'h2) ? relay_two_s : relay_one_s;
   assign wb_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_stb  = wb_req & wb_we_i;
   assign expire  = (state_ff == BFBT_TIMING) && (elapsed_ff >= optime_ff);

   // failure timer
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_ff   <= BFBT_IDLE;
         elapsed_ff <= 32'h0000_0000;
      end
      else
      begin
         case (state_ff)
            BFBT_IDLE:
            begin
               elapsed_ff <= 32'h0000_0000;
               if (watched && !blk_ff)
               begin
                  state_ff <= BFBT_TIMING;
               end
            end
            BFBT_TIMING:
            begin
               if (!watched || blk_ff)
               begin
                  state_ff <= BFBT_IDLE;
               end
               else if (expire)
               begin
                  state_ff <= BFBT_TRIP;
               end
               else
               begin
                  elapsed_ff <= elapsed_ff + 32'h0000_0001;
               end
            end
            BFBT_TRIP:
            begin
               if (!watched)
               begin
                  state_ff <= BFBT_IDLE;
               end
            end
            default:
            begin
               state_ff <= BFBT_IDLE;
            end
         endcase
      end
   end

   // backup must be wired to a separate contact by the board
   assign backup_trip_o = (state_ff == BFBT_TRIP) ||
                          (fstat_ff == `BFBT_ST_TRIPPED);
   assign stage_start_o = (state_ff != BFBT_IDLE) ||
                          (fstat_ff == `BFBT_ST_STARTED);
   assign relay_sel_o   = sel_ff;
   assign force_o       = force_ff;

   always_comb
   begin
      if (fstat_ff != `BFBT_ST_IDLE)
      begin
         status = fstat_ff;
      end
      else if (state_ff == BFBT_TRIP)
      begin
         status = `BFBT_ST_TRIPPED;
      end
      else if (state_ff == BFBT_TIMING)
      begin
         status = `BFBT_ST_STARTED;
      end
      else if (blk_ff)
      begin
         status = `BFBT_ST_BLOCKED;
      end
      else
      begin
         status = `BFBT_ST_IDLE;
      end
   end

   // settings, guarded by password
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         unlock_ff <= 1'b0;
         sel_ff    <= `BFBT_RST_RELAY_SEL;
         blk_ff    <= 1'b0;
         optime_ff <= `BFBT_RST_OPTIME;
      end
      else if (wr_stb)
      begin
         if (wb_adr_i == `BFBT_OFF_PASSWORD)
         begin
            unlock_ff <= (wb_dat_i == `BFBT_PASSWORD_KEY);
         end
         else if (wb_adr_i == `BFBT_OFF_CTRL && unlock_ff && wb_sel_i[0])
         begin
            // only 1 and 2 are legal selections
            if (wb_dat_i[1:0] == 2'h1 || wb_dat_i[1:0] == 2'h2)
            begin
               sel_ff <= wb_dat_i[1:0];
            end
            blk_ff <= wb_dat_i[`BFBT_CTRL_BLK_BIT];
         end
         else if (wb_adr_i == `BFBT_OFF_OPTIME && unlock_ff)
         begin
            optime_ff <= wmask(optime_ff, wb_dat_i, wb_sel_i);
         end
      end
   end

   // force flag with timeout; a write restarts the timeout
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         force_ff     <= 1'b0;
         force_cnt_ff <= 32'h0000_0000;
      end
      else if (wr_stb && wb_adr_i == `BFBT_OFF_FORCE && unlock_ff)
      begin
         force_ff     <= wb_dat_i[0];
         force_cnt_ff <= 32'h0000_0000;
      end
      else if (force_ff)
      begin
         if (force_cnt_ff >= FORCE_CYCLES - 32'h0000_0001)
         begin
            force_ff <= 1'b0;
         end
         force_cnt_ff <= force_cnt_ff + 32'h0000_0001;
      end
   end

   // forced status; refused unless force flag set
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         fstat_ff <= `BFBT_ST_IDLE;
      end
      else if (!force_ff)
      begin
         fstat_ff <= `BFBT_ST_IDLE;
      end
      else if (wr_stb && wb_adr_i == `BFBT_OFF_STATUS && wb_sel_i[0])
      begin
         if (wb_dat_i[1:0] == `BFBT_ST_STARTED ||
             wb_dat_i[1:0] == `BFBT_ST_TRIPPED ||
             wb_dat_i[1:0] == `BFBT_ST_IDLE)
         begin
            fstat_ff <= wb_dat_i[1:0];
         end
      end
   end

   // counters; a count event with a same-cycle clear leaves the count at 1
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         scnt_ff <= 32'h0000_0000;
         tcnt_ff <= 32'h0000_0000;
      end
      else
      begin
         if (state_ff == BFBT_IDLE && watched && !blk_ff)
         begin
            scnt_ff <= (wr_stb && wb_adr_i == `BFBT_OFF_SCNT) ?
                       32'h0000_0001 : scnt_ff + 32'h0000_0001;
         end
         else if (wr_stb && wb_adr_i == `BFBT_OFF_SCNT)
         begin
            scnt_ff <= 32'h0000_0000;
         end
         if (expire && watched && !blk_ff)
         begin
            tcnt_ff <= (wr_stb && wb_adr_i == `BFBT_OFF_TCNT) ?
                       32'h0000_0001 : tcnt_ff + 32'h0000_0001;
         end
         else if (wr_stb && wb_adr_i == `BFBT_OFF_TCNT)
         begin
            tcnt_ff <= 32'h0000_0000;
         end
      end
   end

   // time of day in ms and date, set by software, tod runs on
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ms_cnt_ff <= 32'h0000_0000;
         tod_ff    <= 32'h0000_0000;
         date_ff   <= 32'h0000_0000;
      end
      else if (wr_stb && wb_adr_i == `BFBT_OFF_CLOCK)
      begin
         tod_ff    <= wb_dat_i;
         ms_cnt_ff <= 32'h0000_0000;
      end
      else
      begin
         if (wr_stb && wb_adr_i == `BFBT_OFF_DATE)
         begin
            date_ff <= wb_dat_i;
         end
         if (ms_cnt_ff >= MS_CYCLES - 32'h0000_0001)
         begin
            ms_cnt_ff <= 32'h0000_0000;
            tod_ff    <= tod_ff + 32'h0000_0001;
         end
         else
         begin
            ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
         end
      end
   end

   // fault record on trip, or on early drop or block of a started fault
   assign new_rec = {date_ff,
                     tod_ff,
                     expire ? 16'h0064 :
                     pct(elapsed_ff, optime_ff)};
   assign rec.wr_en   = (state_ff == BFBT_TIMING) &&
                        (expire || !watched || blk_ff);
   assign rec.wr_addr = wptr_ff;
   assign rec.wr_data = new_rec;
   assign rec.rd_addr = wptr_ff - 3'h1 - ridx_ff; // 0 is newest

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wptr_ff <= 3'h0;
         rcnt_ff <= 4'h0;
      end
      else if (rec.wr_en)
      begin
         wptr_ff <= wptr_ff + 3'h1;
         if (rcnt_ff != 4'h8)
         begin
            rcnt_ff <= rcnt_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ridx_ff <= 3'h0;
      end
      else if (wr_stb && wb_adr_i == `BFBT_OFF_REC_IDX)
      begin
         ridx_ff <= wb_dat_i[2:0];
      end
   end

   // read data; ack one cycle after request, memory read lands in time
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= wb_req;
         if (wb_req && !wb_we_i)
         begin
            if (wb_adr_i == `BFBT_OFF_CTRL)
            begin
               dat_ff <= {27'h0, blk_ff, 2'h0, sel_ff};
            end
            else if (wb_adr_i == `BFBT_OFF_STATUS)
            begin
               dat_ff <= {30'h0, status};
            end
            else if (wb_adr_i == `BFBT_OFF_OPTIME)
            begin
               dat_ff <= optime_ff;
            end
            else if (wb_adr_i == `BFBT_OFF_SCNT)
            begin
               dat_ff <= scnt_ff;
            end
            else if (wb_adr_i == `BFBT_OFF_TCNT)
            begin
               dat_ff <= tcnt_ff;
            end
            else if (wb_adr_i == `BFBT_OFF_FORCE)
            begin
               dat_ff <= {30'h0, unlock_ff, force_ff};
            end
            else if (wb_adr_i == `BFBT_OFF_CLOCK)
            begin
               dat_ff <= tod_ff;
            end
            else if (wb_adr_i == `BFBT_OFF_DATE)
            begin
               dat_ff <= date_ff;
            end
            else if (wb_adr_i == `BFBT_OFF_REC_IDX)
            begin
               dat_ff <= {29'h0, ridx_ff};
            end
            else if (wb_adr_i == `BFBT_OFF_REC_DATE)
            begin
               dat_ff <= rec.rd_data.date;
            end
            else if (wb_adr_i == `BFBT_OFF_REC_TIME)
            begin
               dat_ff <= rec.rd_data.tod_ms;
            end
            else if (wb_adr_i == `BFBT_OFF_REC_ELAPSED_DELAY_PERCENT)
            begin
               dat_ff <= {16'h0, rec.rd_data.elapsed_delay_percent_pct};
            end
            else if (wb_adr_i == `BFBT_OFF_REC_CNT)
            begin
               dat_ff <= {28'h0, rcnt_ff};
            end
            else
            begin
               dat_ff <= 32'h0000_0000; // unmapped reads zero
            end
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
endmodule

// ---- design/bfbt_cfg.svh ----
`ifndef BFBT_CFG_SVH
`define BFBT_CFG_SVH
// byte offsets on the wishbone slave
`define BFBT_OFF_CTRL      8'h00
`define BFBT_OFF_STATUS    8'h04
`define BFBT_OFF_OPTIME    8'h08
`define BFBT_OFF_SCNT      8'h0C
`define BFBT_OFF_TCNT      8'h10
`define BFBT_OFF_FORCE     8'h14
`define BFBT_OFF_PASSWORD  8'h18
`define BFBT_OFF_CLOCK     8'h1C
`define BFBT_OFF_DATE      8'h20
`define BFBT_OFF_REC_IDX   8'h24
`define BFBT_OFF_REC_DATE  8'h28
`define BFBT_OFF_REC_TIME  8'h2C
`define BFBT_OFF_REC_ELAPSED_DELAY_PERCENT  8'h30
`define BFBT_OFF_REC_CNT   8'h34
// control register fields
`define BFBT_CTRL_SEL_LSB  0
`define BFBT_CTRL_BLK_BIT  4
`define BFBT_RST_RELAY_SEL 2'h1
`define BFBT_RST_OPTIME    32'h0000_00C8
// status codes
`define BFBT_ST_IDLE       2'h0
`define BFBT_ST_BLOCKED    2'h1
`define BFBT_ST_STARTED    2'h2
`define BFBT_ST_TRIPPED    2'h3
// software key that unlocks settings
`define BFBT_PASSWORD_KEY  32'h0000_5A5A
// timing, clock is 10 MHz
// unsigned 32-bit terms, the five minute count overflows a signed int
`define BFBT_CLK_HZ        32'h0098_9680
`define BFBT_MS_CYCLES     (`BFBT_CLK_HZ / 32'h0000_03E8)
`define BFBT_FORCE_MIN     32'h0000_0005
`define BFBT_FORCE_CYCLES  (`BFBT_FORCE_MIN * 32'h0000_003C * `BFBT_CLK_HZ)
`define BFBT_REC_DEPTH     8
`define BFBT_REC_AW        3
`endif

// ---- design/bfbt_pkg.sv ----
package bfbt_pkg;
   typedef enum logic [1:0] {BFBT_IDLE, BFBT_TIMING, BFBT_TRIP}
      bfbt_state_e;
   typedef struct packed {
      logic [31:0] date;
      logic [31:0] tod_ms;
      logic [15:0] elapsed_delay_percent_pct;
   } bfbt_rec_s;
endpackage

// ---- design/bfbt_rec_if.sv ----
`timescale 1ns/1ps
interface bfbt_rec_if;
   import bfbt_pkg::*;
   logic            wr_en;
   logic [2:0]      wr_addr;
   bfbt_rec_s       wr_data;
   logic [2:0]      rd_addr;
   bfbt_rec_s       rd_data;
   modport writer (output wr_en, output wr_addr, output wr_data,
                   output rd_addr, input rd_data);
   modport mem    (input wr_en, input wr_addr, input wr_data,
                   input rd_addr, output rd_data);
endinterface

// ---- design/bfbt_rec_mem.sv ----
`timescale 1ns/1ps
module bfbt_rec_mem
(
   input  wire logic  clk_sys_i,   // system clock
   bfbt_rec_if.mem    rec          // record port
);
   import bfbt_pkg::*;
   bfbt_rec_s mem_ff [0:7];
   bfbt_rec_s rd_ff;

   always_ff @(posedge clk_sys_i)
   begin
      if (rec.wr_en)
      begin
         mem_ff[rec.wr_addr] <= rec.wr_data;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      rd_ff <= mem_ff[rec.rd_addr];
   end

   assign rec.rd_data = rd_ff;
endmodule

// ---- design/bfbt_sync.sv ----
`timescale 1ns/1ps
module bfbt_sync
(
   input  wire logic  clk_sys_i,   // system clock
   input  wire logic  resetn_i,    // async reset, low
   input  wire logic  d_i,         // async level in
   output logic       q_o          // synchronised level
);
   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule

// ---- verif/bfbt_breaker_failure_stage_bench.sv ----
`timescale 1ns/1ps
`include "bfbt_cfg.svh"
module bfbt_breaker_failure_stage_bench;
   localparam logic [31:0] FC = 32'h0000_00C8;
   logic        clk_sys_i, resetn_i, cyc, stb, we, go, which;
   logic        ack, bkp, start, frc, r1, r2, busy;
   logic [1:0]  rsel;
   logic [3:0]  sel;
   logic [7:0]  adr;
   logic [15:0] len;
   logic [31:0] dat_w, dat_r, dt;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int          fail_count, checked, cyc_n, op, t;
   logic [7:0]  ra[8] = '{`BFBT_OFF_CTRL, `BFBT_OFF_STATUS, `BFBT_OFF_OPTIME,
      `BFBT_OFF_SCNT, `BFBT_OFF_TCNT, `BFBT_OFF_FORCE, `BFBT_OFF_REC_CNT,
      8'h3C};
   logic [31:0] rv[8] = '{32'h1, 32'h0, `BFBT_RST_OPTIME, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0};

   bfbt_breaker_failure_stage #(.FORCE_CYCLES(FC), .MS_CYCLES(32'hA))
   bfbt_breaker_failure_stage_i (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .trip_relay_one_i(r1), .trip_relay_two_i(r2),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .backup_trip_o(bkp), .stage_start_o(start), .relay_sel_o(rsel),
      .force_o(frc));

   bfbt_relay_model bfbt_relay_model_i (.clk_sys_i(clk_sys_i), .go_i(go),
      .which_i(which), .len_i(len), .relay_one_o(r1), .relay_two_o(r2),
      .busy_o(busy));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // reads carry their expected data in d
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      exp_q.push_back({~w, d});
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do
      begin
         @(posedge clk_sys_i);
      end
      while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic pulse(input logic w2, input int n);
      go <= 1'b1;
      which <= w2;
      len <= 16'(n);
      @(posedge clk_sys_i);
      go <= 1'b0;
   endtask

   task automatic till_trip(output int c);
      c = 0;
      while (bkp !== 1'b1 && c < op + 20)
      begin
         step(1);
         c++;
      end
   endtask

   task automatic till_idle();
      while (busy === 1'b1)
         step(1);
   endtask

   // read data is sampled at the ack edge, before it can move on
   always @(posedge clk_sys_i)
      if (ack === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         if (e[32])
            chk(dat_r, e[31:0]);
      end

   always @(posedge clk_sys_i)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial
   begin
      resetn_i = 1'b0;
      {cyc, stb, we, go, which} = 5'h0;
      adr = 8'h0;
      sel = 4'hF;
      len = 16'h0;
      dat_w = 32'h0;
      void'($urandom(32'h0000_CB18));
      step(8);
      resetn_i <= 1'b1;
      step(1);
      foreach (ra[i]) wb(1'b0, ra[i], rv[i]);
      chk(32'(rsel), 32'h1);
      wb(1'b1, `BFBT_OFF_OPTIME, 32'h5);
      wb(1'b0, `BFBT_OFF_OPTIME, `BFBT_RST_OPTIME);
      wb(1'b1, `BFBT_OFF_PASSWORD, `BFBT_PASSWORD_KEY);
      wb(1'b0, `BFBT_OFF_FORCE, 32'h2);
      op = 40 + $urandom % 21;
      wb(1'b1, `BFBT_OFF_OPTIME, 32'(op));
      wb(1'b0, `BFBT_OFF_OPTIME, 32'(op));
      dt = $urandom;
      wb(1'b1, `BFBT_OFF_DATE, dt);
      wb(1'b1, `BFBT_OFF_CLOCK, dt);
      wb(1'b0, `BFBT_OFF_CLOCK, dt);
      pulse(1'b0, op + 30);
      step(5);
      chk(32'(start), 32'h1);
      till_trip(t);
      chk(32'(t >= op - 5 && t <= op + 8), 32'h1);
      wb(1'b0, `BFBT_OFF_STATUS, 32'h3);
      till_idle();
      chk(32'(bkp), 32'h1);
      step(5);
      chk(32'(bkp), 32'h0);
      wb(1'b1, `BFBT_OFF_REC_IDX, 32'h0);
      step(2);
      wb(1'b0, `BFBT_OFF_REC_ELAPSED_DELAY_PERCENT, 32'h64);
      wb(1'b0, `BFBT_OFF_REC_DATE, dt);
      // short commands: started, never tripped, fill the record store
      for (int i = 0; i < 8; i++)
      begin
         pulse(1'b0, 14 + $urandom % (op / 2 - 13));
         step(5);
         wb(1'b0, `BFBT_OFF_STATUS, 32'h2);
         till_idle();
         step(5);
         chk(32'({bkp, start}), 32'h0);
      end
      wb(1'b0, `BFBT_OFF_SCNT, 32'h9);
      wb(1'b0, `BFBT_OFF_REC_CNT, 32'h8);
      pulse(1'b1, 20);
      step(8);
      chk(32'(start), 32'h0);
      till_idle();
      wb(1'b1, `BFBT_OFF_CTRL, 32'h2);
      wb(1'b1, `BFBT_OFF_CTRL, 32'h3);
      wb(1'b0, `BFBT_OFF_CTRL, 32'h2);
      chk(32'(rsel), 32'h2);
      pulse(1'b1, op + 30);
      till_trip(t);
      chk(32'(bkp), 32'h1);
      till_idle();
      step(5);
      wb(1'b0, `BFBT_OFF_TCNT, 32'h2);
      wb(1'b1, `BFBT_OFF_SCNT, $urandom);
      wb(1'b1, `BFBT_OFF_TCNT, $urandom);
      wb(1'b0, `BFBT_OFF_SCNT, 32'h0);
      wb(1'b0, `BFBT_OFF_TCNT, 32'h0);
      wb(1'b1, `BFBT_OFF_CTRL, 32'h11);
      wb(1'b0, `BFBT_OFF_STATUS, 32'h1);
      wb(1'b1, `BFBT_OFF_CTRL, 32'h1);
      wb(1'b1, `BFBT_OFF_STATUS, 32'h3);
      wb(1'b0, `BFBT_OFF_STATUS, 32'h0);
      wb(1'b1, `BFBT_OFF_FORCE, 32'h1);
      wb(1'b0, `BFBT_OFF_FORCE, 32'h3);
      wb(1'b1, `BFBT_OFF_STATUS, 32'h2);
      chk(32'({bkp, start}), 32'h1);
      wb(1'b1, `BFBT_OFF_STATUS, 32'h3);
      wb(1'b0, `BFBT_OFF_STATUS, 32'h3);
      chk(32'(bkp), 32'h1);
      step(FC + 10);
      chk(32'(frc), 32'h0);
      wb(1'b0, `BFBT_OFF_STATUS, 32'h0);
      wb(1'b1, `BFBT_OFF_PASSWORD, 32'h0);
      wb(1'b1, `BFBT_OFF_OPTIME, 32'h7);
      wb(1'b0, `BFBT_OFF_OPTIME, 32'(op));
      step(3);
      tally_and_finish();
   end
endmodule

bind bfbt_breaker_failure_stage bfbt_monitor #(.FORCE_CYCLES(FORCE_CYCLES))
   bfbt_monitor_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
   .trip_relay_one_i(trip_relay_one_i), .trip_relay_two_i(trip_relay_two_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .backup_trip_o(backup_trip_o), .stage_start_o(stage_start_o),
   .relay_sel_o(relay_sel_o), .force_o(force_o));

// ---- verif/bfbt_monitor.sv ----
`timescale 1ns/1ps
module bfbt_monitor
#(
   parameter logic [31:0] FORCE_CYCLES = 32'h0000_00C8 // force timeout
)
(
   input  wire logic       clk_sys_i,        // clock
   input  wire logic       resetn_i,         // async reset, low
   input  wire logic       trip_relay_one_i, // relay one control
   input  wire logic       trip_relay_two_i, // relay two control
   input  wire logic       wb_cyc_i,         // cycle
   input  wire logic       wb_stb_i,         // strobe
   input  wire logic       wb_ack_o,         // acknowledge
   input  wire logic       backup_trip_o,    // backup relay
   input  wire logic       stage_start_o,    // start indication
   input  wire logic [1:0] relay_sel_o,      // relay selection
   input  wire logic       force_o           // force flag
);
   logic        sup;
   logic [31:0] force_run_ff;

   assign sup = (relay_sel_o == 2'h2) ? trip_relay_two_i : trip_relay_one_i;

   // run length of the force flag, zero whenever it is off
   always_ff @(posedge clk_sys_i or negedge resetn_i)
      if (!resetn_i)
         force_run_ff <= 32'h0;
      else
         force_run_ff <= force_o ? force_run_ff + 32'h1 : 32'h0;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_sup_up;
      $rose(sup) && !force_o;
   endsequence

   property p_ack_answer;
      s_req |=> s_ack_once;
   endproperty
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_start_on;
      s_sup_up |-> ##[1:4] (stage_start_o || backup_trip_o || !sup);
   endproperty
   property p_start_off;
      $fell(sup) && !force_o |-> ##[1:4] !(stage_start_o || backup_trip_o);
   endproperty
   property p_trip_cause;
      $rose(backup_trip_o) && !force_o |->
         $past(stage_start_o) && $past(sup, 3);
   endproperty
   property p_trip_hold;
      $fell(backup_trip_o) && !$past(force_o) |-> !$past(sup);
   endproperty
   property p_sel_legal;
      relay_sel_o == 2'h1 || relay_sel_o == 2'h2;
   endproperty
   property p_force_limit;
      force_run_ff <= FORCE_CYCLES + 32'h2;
   endproperty

   a_ack_answer: assert property (p_ack_answer)
      else $error("request not acked once in next cycle");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_start_on: assert property (p_start_on)
      else $error("start missing after relay rise");
   a_start_off: assert property (p_start_off)
      else $error("start or backup stuck after relay drop");
   a_trip_cause: assert property (p_trip_cause)
      else $error("backup rose without timed start");
   a_trip_hold: assert property (p_trip_hold)
      else $error("backup released while relay active");
   a_sel_legal: assert property (p_sel_legal)
      else $error("relay selection not 1 or 2");
   a_force_limit: assert property (p_force_limit)
      else $error("force flag outlived its timeout");
endmodule

// ---- verif/bfbt_relay_model.sv ----
`timescale 1ns/1ps
// backup contact is never one of these two
module bfbt_relay_model
(
   input  wire logic        clk_sys_i,   // clock
   input  wire logic        go_i,        // start one trip command
   input  wire logic        which_i,     // 0 relay one, 1 relay two
   input  wire logic [15:0] len_i,       // command length, cycles
   output logic             relay_one_o, // relay one control
   output logic             relay_two_o, // relay two control
   output logic             busy_o       // command active
);
   logic [15:0] left_ff;
   logic        which_ff;

   initial
   begin
      left_ff = 16'h0;
      which_ff = 1'b0;
   end

   // control level held for the whole command
   always @(posedge clk_sys_i)
      if (go_i)
      begin
         left_ff <= len_i;
         which_ff <= which_i;
      end
      else if (left_ff != 16'h0)
         left_ff <= left_ff - 16'h1;

   assign busy_o = (left_ff != 16'h0);
   assign relay_one_o = busy_o && !which_ff;
   assign relay_two_o = busy_o && which_ff;
endmodule
